//--- verilog/logic_slice_lut_mux_carry.sv
// Function
// RULE1: two four-input tables, each programmable to any four-input Boolean function
// RULE2: tables can also act as sixteen-bit distributed RAM or shift register
// RULE3: lower wide mux passes input0 on select low, input1 on high, both outputs
// RULE4: wide muxes give a local cascade output and a general output
// RULE5: lower wide mux selects between the two table outputs, any five-input function
// RULE6: upper cascade mux selects between two dedicated feedback inputs
// RULE7: two table 2:1 muxes combine into a 4:1 mux through lower wide mux
// RULE8: seven-input cascade position has feedback input from block below
// RULE9: carry enters at carry_in, leaves at carry_out toward block above
// RULE10: carry initializer picks carry_in or lower bypass input by configuration
// RULE11: carry-generate source is input1, input2, AND gate, bypass, one or zero
// RULE12: lower carry mux propagates initialized carry on 1, generate value on 0
// RULE13: upper carry mux propagates lower carry on 1, upper generate on 0
// RULE14: propagate select comes from table output or constant one
// RULE15: lower sum is lower table output XOR initialized carry
// RULE16: upper sum is upper table output XOR lower carry mux output
// RULE17: partial-product gate ANDs inputs 1 and 2, routable as carry generate
// RULE18: table half-sum plus carry mux and sum gate give two adder bits
// RULE19: table, mux and carry paths are combinational; only table contents are stored
module logic_slice_lut_mux_carry #(
    parameter int DEPTH = logic_slice_pkg::LUT_DEPTH
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic_slice_pkg::slice_cfg_t CFG_I,
    input wire logic [15:0] LOWER_INIT_I,
    input wire logic [15:0] UPPER_INIT_I,
    input wire logic LOAD_INIT_I,
    input wire logic [3:0] LOWER_IN_I,
    input wire logic [3:0] UPPER_IN_I,
    input wire logic LOWER_BYPASS_INPUT_I,
    input wire logic UPPER_BYPASS_INPUT_I,
    input wire logic CASCADE_FEEDBACK_INPUT_A_I,
    input wire logic CASCADE_FEEDBACK_INPUT_B_I,
    input wire logic CARRY_IN_I,
    input wire logic WRITE_ENABLE_I,
    input wire logic LOWER_DATA_I,
    input wire logic UPPER_DATA_I,
    output logic LOWER_LUT_O,
    output logic UPPER_LUT_O,
    output logic FIVE_INPUT_MUX_O,
    output logic FIVE_INPUT_MUX_LOCAL_O,
    output logic CASCADE_MUX_O,
    output logic CASCADE_MUX_LOCAL_O,
    output logic LOWER_SUM_O,
    output logic UPPER_SUM_O,
    output logic CARRY_OUT_O,
    output logic SHIFT_OUT_O
);

    logic_slice_pkg::slice_state_t state;
    logic_slice_pkg::slice_state_t next_state;

    logic lower_lut;
    logic upper_lut;
    logic carry_init;
    logic lower_gen;
    logic upper_gen;
    logic lower_sel;
    logic upper_sel;
    logic lower_carry;

    function automatic logic lut_read(input logic [15:0] table_bits, input logic [3:0] addr);
        lut_read = table_bits[addr];
    endfunction

    function automatic logic carry_gen(input logic_slice_pkg::carry_gen_src_t src,
                                       input logic [3:0] in, input logic bypass);
        case (src)
            logic_slice_pkg::GEN_INPUT1: carry_gen = in[0];
            logic_slice_pkg::GEN_INPUT2: carry_gen = in[1];
            logic_slice_pkg::GEN_AND: carry_gen = in[0] & in[1]; // RULE17
            logic_slice_pkg::GEN_BYPASS: carry_gen = bypass;
            logic_slice_pkg::GEN_ONE: carry_gen = 1'b1;
            default: carry_gen = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] table_update(input logic [15:0] table_bits,
                                                 input logic_slice_pkg::lut_mode_t mode,
                                                 input logic [3:0] addr, input logic din);
        logic [15:0] t;
        t = table_bits;
        case (mode)
            logic_slice_pkg::LUT_MODE_RAM: t[addr] = din; // RULE2
            logic_slice_pkg::LUT_MODE_SHIFT: t = {t[14:0], din}; // RULE2
            default: t = table_bits;
        endcase
        table_update = t;
    endfunction

    // table contents are the only state; datapath below stays combinational
    always_comb begin
        next_state = state;
        if (LOAD_INIT_I) begin
            next_state.lower_table = LOWER_INIT_I; // RULE1
            next_state.upper_table = UPPER_INIT_I; // RULE1
        end else if (WRITE_ENABLE_I) begin
            next_state.lower_table = table_update(state.lower_table, CFG_I.lower_mode, LOWER_IN_I, LOWER_DATA_I);
            // upper shift register chains from the lower one's last bit
            next_state.upper_table = table_update(state.upper_table, CFG_I.upper_mode, UPPER_IN_I,
                (CFG_I.upper_mode == logic_slice_pkg::LUT_MODE_SHIFT) ? state.lower_table[15] : UPPER_DATA_I);
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= '{lower_table: logic_slice_pkg::LUT_INIT_RESET, upper_table: logic_slice_pkg::LUT_INIT_RESET};
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        lower_lut = lut_read(state.lower_table, LOWER_IN_I); // RULE1 RULE19
        upper_lut = lut_read(state.upper_table, UPPER_IN_I); // RULE1 RULE19
        carry_init = CFG_I.carry_init_from_bypass ? LOWER_BYPASS_INPUT_I : CARRY_IN_I; // RULE10
        lower_gen = carry_gen(CFG_I.lower_gen_src, LOWER_IN_I, LOWER_BYPASS_INPUT_I); // RULE11
        upper_gen = carry_gen(CFG_I.upper_gen_src, UPPER_IN_I, UPPER_BYPASS_INPUT_I); // RULE11
        lower_sel = CFG_I.lower_prop_always | lower_lut; // RULE14
        upper_sel = CFG_I.upper_prop_always | upper_lut; // RULE14
        lower_carry = lower_sel ? carry_init : lower_gen; // RULE12 RULE18
    end

    assign LOWER_LUT_O = lower_lut;
    assign UPPER_LUT_O = upper_lut;
    assign FIVE_INPUT_MUX_O = LOWER_BYPASS_INPUT_I ? upper_lut : lower_lut; // RULE3 RULE5 RULE7
    assign FIVE_INPUT_MUX_LOCAL_O = LOWER_BYPASS_INPUT_I ? upper_lut : lower_lut; // RULE3 RULE4
    // input A carries the feedback from below in the seven-input position
    assign CASCADE_MUX_O = UPPER_BYPASS_INPUT_I ? CASCADE_FEEDBACK_INPUT_B_I : CASCADE_FEEDBACK_INPUT_A_I; // RULE6 RULE8
    assign CASCADE_MUX_LOCAL_O = UPPER_BYPASS_INPUT_I ? CASCADE_FEEDBACK_INPUT_B_I : CASCADE_FEEDBACK_INPUT_A_I; // RULE4
    assign LOWER_SUM_O = lower_lut ^ carry_init; // RULE15 RULE18
    assign UPPER_SUM_O = upper_lut ^ lower_carry; // RULE16 RULE18
    assign CARRY_OUT_O = upper_sel ? lower_carry : upper_gen; // RULE13 RULE9
    assign SHIFT_OUT_O = state.upper_table[15];

endmodule // logic_slice_lut_mux_carry

//--- verilog/logic_slice_pkg.sv
package logic_slice_pkg;

    localparam int LUT_INPUTS = 4;
    localparam int LUT_DEPTH = 16;
    localparam logic [15:0] LUT_INIT_RESET = 16'h0000;

    // lut mode, one-hot
    typedef enum logic [2:0] {
        LUT_MODE_LOGIC = 3'h1,
        LUT_MODE_RAM = 3'h2,
        LUT_MODE_SHIFT = 3'h4
    } lut_mode_t;

    // carry-generate source, one-hot
    typedef enum logic [5:0] {
        GEN_INPUT1 = 6'h01,
        GEN_INPUT2 = 6'h02,
        GEN_AND = 6'h04,
        GEN_BYPASS = 6'h08,
        GEN_ONE = 6'h10,
        GEN_ZERO = 6'h20
    } carry_gen_src_t;

    typedef struct packed {
        lut_mode_t lower_mode;
        lut_mode_t upper_mode;
        logic carry_init_from_bypass;
        carry_gen_src_t lower_gen_src;
        carry_gen_src_t upper_gen_src;
        logic lower_prop_always;
        logic upper_prop_always;
    } slice_cfg_t;

    typedef struct packed {
        logic [15:0] lower_table;
        logic [15:0] upper_table;
    } slice_state_t;

    localparam slice_cfg_t CFG_RESET = '{
        lower_mode: LUT_MODE_LOGIC,
        upper_mode: LUT_MODE_LOGIC,
        carry_init_from_bypass: 1'b0,
        lower_gen_src: GEN_ZERO,
        upper_gen_src: GEN_ZERO,
        lower_prop_always: 1'b0,
        upper_prop_always: 1'b0
    };

endpackage

//--- bench/neighbour_slice_model.sv
module neighbour_slice_model (
    input wire logic [2:0] drive_i,
    output logic carry_o,
    output logic feed_a_o,
    output logic feed_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // slice below: its carry-out and its wide-mux feedback lines
    assign {carry_o, feed_a_o, feed_b_o} = drive_i;
endmodule // neighbour_slice_model

//--- bench/logic_slice_lut_mux_carry_assertions.sv
module logic_slice_lut_mux_carry_checker (
    input wire logic MCLK_I, RST_N_I, LOAD_INIT_I, CARRY_IN_I,
    input wire logic_slice_pkg::slice_cfg_t CFG_I,
    input wire logic [15:0] LOWER_INIT_I,
    input wire logic [3:0] LOWER_IN_I,
    input wire logic LOWER_BYPASS_INPUT_I, UPPER_BYPASS_INPUT_I,
    input wire logic CASCADE_FEEDBACK_INPUT_A_I, CASCADE_FEEDBACK_INPUT_B_I,
    input wire logic LOWER_LUT_O, UPPER_LUT_O, LOWER_SUM_O, UPPER_SUM_O, CARRY_OUT_O,
    input wire logic FIVE_INPUT_MUX_O, FIVE_INPUT_MUX_LOCAL_O, CASCADE_MUX_O, CASCADE_MUX_LOCAL_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    logic ini, ls, us;
    assign ini = CFG_I.carry_init_from_bypass ? LOWER_BYPASS_INPUT_I : CARRY_IN_I;
    assign ls = LOWER_LUT_O | CFG_I.lower_prop_always;
    assign us = UPPER_LUT_O | CFG_I.upper_prop_always;
    property p_load;
        logic [15:0] t;
        (LOAD_INIT_I, t = LOWER_INIT_I) |=> LOWER_LUT_O == t[LOWER_IN_I];
    endproperty
    AST_LOAD: assert property (p_load) else $error("lookup");
    AST_WIDE: assert property (FIVE_INPUT_MUX_O == (LOWER_BYPASS_INPUT_I ? UPPER_LUT_O : LOWER_LUT_O)
        && FIVE_INPUT_MUX_LOCAL_O == FIVE_INPUT_MUX_O) else $error("wide mux");
    AST_CASC: assert property (CASCADE_MUX_LOCAL_O == CASCADE_MUX_O && CASCADE_MUX_O ==
        (UPPER_BYPASS_INPUT_I ? CASCADE_FEEDBACK_INPUT_B_I : CASCADE_FEEDBACK_INPUT_A_I)) else $error("cascade");
    AST_LSUM: assert property (LOWER_SUM_O == (LOWER_LUT_O ^ ini)) else $error("lower sum");
    AST_USUM: assert property (ls |-> UPPER_SUM_O == (UPPER_LUT_O ^ ini)) else $error("upper sum");
    AST_PROP: assert property (ls && us |-> CARRY_OUT_O == ini) else $error("propagate");
    AST_CHAIN: assert property (ls && us && !CFG_I.carry_init_from_bypass |-> CARRY_OUT_O == CARRY_IN_I)
        else $error("chain");
    AST_GEN: assert property (!us && CFG_I.upper_gen_src[5:4] != 2'h0 |-> CARRY_OUT_O == CFG_I.upper_gen_src[4])
        else $error("generate");
endmodule // logic_slice_lut_mux_carry_checker
bind logic_slice_lut_mux_carry logic_slice_lut_mux_carry_checker logic_slice_lut_mux_carry_checker_inst (.*);

//--- bench/logic_slice_lut_mux_carry_bench.sv
module logic_slice_lut_mux_carry_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, load = 1'b0, lbyp = 1'b0, ubyp = 1'b0;
    logic carry_in, fa, fb, llut, f5, cm, lsum, usum, carry_out;
    logic ulut, f5l, cml, shout;
    logic we = 1'b0, ld = 1'b0;
    logic [2:0] nb = 3'h0, r;
    logic [3:0] lin = 4'h0, uin = 4'h0;
    logic [15:0] li = 16'h0000;
    logic_slice_pkg::slice_cfg_t cfg = logic_slice_pkg::CFG_RESET;
    int err_total = 0, num_checks = 0;
    neighbour_slice_model neighbour_slice_model_inst (.drive_i(nb), .carry_o(carry_in), .feed_a_o(fa), .feed_b_o(fb));
    logic_slice_lut_mux_carry logic_slice_lut_mux_carry_inst (.MCLK_I(clk), .RST_N_I(rst_n), .CFG_I(cfg),
        .LOWER_INIT_I(li), .UPPER_INIT_I(li), .LOAD_INIT_I(load), .LOWER_IN_I(lin), .UPPER_IN_I(uin),
        .LOWER_BYPASS_INPUT_I(lbyp), .UPPER_BYPASS_INPUT_I(ubyp), .CASCADE_FEEDBACK_INPUT_A_I(fa),
        .CASCADE_FEEDBACK_INPUT_B_I(fb), .CARRY_IN_I(carry_in), .WRITE_ENABLE_I(we), .LOWER_DATA_I(ld),
        .UPPER_DATA_I(ld), .LOWER_LUT_O(llut), .UPPER_LUT_O(ulut), .FIVE_INPUT_MUX_O(f5),
        .FIVE_INPUT_MUX_LOCAL_O(f5l), .CASCADE_MUX_O(cm), .CASCADE_MUX_LOCAL_O(cml), .LOWER_SUM_O(lsum),
        .UPPER_SUM_O(usum), .CARRY_OUT_O(carry_out), .SHIFT_OUT_O(shout));
    task automatic ck(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // both tables hold a half-sum: xor of inputs 1 and 2
    task automatic t_add;
        step;
        li = 16'h6666;
        load = 1'b1;
        cfg.lower_gen_src = logic_slice_pkg::GEN_INPUT1;
        cfg.upper_gen_src = logic_slice_pkg::GEN_INPUT1;
        for (int v = 0; v < 32; v++) begin
            step;
            load = 1'b0;
            lin = {2'h0, v[2], v[0]};
            uin = {2'h0, v[3], v[1]};
            {lbyp, ubyp} = v[1:0];
            nb = v[4:2];
            r = v[1:0] + v[3:2] + v[4];
            #1;
            ck("lower_sum", r[0], lsum);
            ck("upper_sum", r[1], usum);
            ck("carry_out", r[2], carry_out);
            ck("wide_mux", v[1] ? v[1] ^ v[3] : v[0] ^ v[2], f5);
            ck("cascade_mux", v[0] ? v[2] : v[3], cm);
            ck("wide_mux_local", v[1] ? v[1] ^ v[3] : v[0] ^ v[2], f5l);
            ck("cascade_mux_local", v[0] ? v[2] : v[3], cml);
        end
    endtask
    // tables empty so both halves generate from the chosen source
    task automatic t_gen;
        step;
        li = 16'h0000;
        load = 1'b1;
        for (int s = 0; s < 6; s++) begin
            cfg.lower_gen_src = logic_slice_pkg::carry_gen_src_t'(6'h01 << s);
            cfg.upper_gen_src = cfg.lower_gen_src;
            for (int i = 0; i < 8; i++) begin
                step;
                load = 1'b0;
                lin = {2'h0, i[1:0]};
                uin = lin;
                {lbyp, ubyp} = {2{i[2]}};
                r[0] = s == 0 ? i[0] : s == 1 ? i[1] : s == 2 ? i[0] & i[1] : s == 3 ? i[2] : s == 4;
                #1;
                ck("carry_out", r[0], carry_out);
                ck("upper_sum", r[0], usum);
            end
        end
    endtask
    task automatic t_init;
        cfg.lower_prop_always = 1'b1;
        cfg.upper_prop_always = 1'b1;
        for (int i = 0; i < 4; i++) begin
            step;
            cfg.carry_init_from_bypass = i[1];
            lbyp = i[0];
            nb = {!i[0], 2'h0};
            #1;
            ck("carry_out", i[1] ? i[0] : !i[0], carry_out);
        end
    endtask
    // lower table as ram keeps bit 15 set; upper table shifts it in from below
    task automatic t_mem;
        step;
        cfg.lower_mode = logic_slice_pkg::LUT_MODE_RAM;
        cfg.upper_mode = logic_slice_pkg::LUT_MODE_SHIFT;
        we = 1'b1;
        ld = 1'b1;
        lin = 4'hF;
        uin = 4'h0;
        for (int n = 0; n < 17; n++) begin
            step;
            #1;
            ck("upper_lut", n > 0, ulut);
            ck("shift_out", n == 16, shout);
            ck("lower_lut", 1'b1, llut);
        end
        step;
        cfg.lower_mode = logic_slice_pkg::LUT_MODE_LOGIC;
        cfg.upper_mode = logic_slice_pkg::LUT_MODE_LOGIC;
        ld = 1'b0;
        step;
        we = 1'b0;
        #1;
        ck("lower_lut", 1'b1, llut);
        ck("shift_out", 1'b1, shout);
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        #20000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        ck("lower_lut", 1'b0, llut);
        t_add;
        t_gen;
        t_init;
        t_mem;
        test_done;
    end
endmodule // logic_slice_lut_mux_carry_bench
